/* hdl/pin_route.sv */
`timescale 1ns/1ps
module pin_route (
  pwm_route_if.route rt
);
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      // Disabled pin releases to generic I/O
      assign rt.pin_o[g] = rt.enable[g] & rt.timer_out[g];
      assign rt.pin_oe_n[g] = ~(rt.enable[g] & rt.timer_oe[g]);
    end
  endgenerate
endmodule : pin_route

/* hdl/pwm_comb_ctrl.sv */
`timescale 1ns/1ps
module pwm_comb_ctrl
  import pwm_comb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ch1_capture_a_i,
  input wire logic ch3_pwm_select_i,
  input wire logic ch4_pwm_select_i,
  input wire logic ch3_sync_select_i,
  input wire logic ch4_sync_select_i,
  input wire logic [5:0] timer_out_i,
  input wire logic [5:0] timer_oe_i,
  output logic [1:0] comb_mode_o,
  output logic ch3_pwm_eff_o,
  output logic ch4_pwm_eff_o,
  output logic ch3_sync_eff_o,
  output logic ch4_sync_eff_o,
  output logic [3:0] buffer_select_o,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe_n_o
);
  typedef struct packed {
    logic [5:0] comb;
    logic [5:0] enable;
    logic trig_disable;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;
  logic req;
  logic wr;
  logic combined;
  logic [7:0] comb_rd;
  logic [7:0] en_rd;
  pwm_route_if rt ();

  assign req = cyc_i & stb_i & ~st.ack;
  assign wr = req & we_i & sel_i[0];
  assign comb_rd = reserved_mask | {2'b00, st.comb};
  assign en_rd = reserved_mask | {2'b00, st.enable};
  assign combined = st.comb[mode_lsb+1];

  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    if (req && !we_i) begin
      unique case (adr_i)
        addr_comb_ctrl: next_st.rdata = {24'h00_0000, comb_rd};
        addr_out_enable: next_st.rdata = {24'h00_0000, en_rd};
        addr_trig_ctrl: next_st.rdata = {31'h0000_0000, st.trig_disable};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (adr_i)
        addr_comb_ctrl: next_st.comb = dat_i[5:0];
        addr_out_enable: next_st.enable = dat_i[5:0];
        addr_trig_ctrl: next_st.trig_disable = dat_i[trig_disable_bit];
        default: next_st.comb = st.comb;
      endcase
    end
    // Hardware clear wins over a software write in the same cycle
    if (ch1_capture_a_i && !st.trig_disable && combined) begin
      next_st.enable = 6'h00;
    end
    if (standby_i) begin
      next_st.comb = comb_ctrl_reset[5:0];
      next_st.enable = out_enable_reset[5:0];
      next_st.trig_disable = trig_ctrl_reset[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.comb <= comb_ctrl_reset[5:0];
      st.enable <= out_enable_reset[5:0];
      st.trig_disable <= trig_ctrl_reset[0];
    end else begin
      st <= next_st;
    end
  end

  assign ack_o = st.ack;
  assign dat_o = st.rdata;
  assign comb_mode_o = st.comb[5:4];
  assign buffer_select_o = st.comb[3:0];
  assign ch3_pwm_eff_o = ch3_pwm_select_i & ~combined;
  assign ch4_pwm_eff_o = ch4_pwm_select_i & ~combined;
  assign ch3_sync_eff_o = ch3_sync_select_i;
  assign ch4_sync_eff_o = ch4_sync_select_i;

  assign rt.combined = combined;
  assign rt.enable = st.enable;
  assign rt.timer_out = timer_out_i;
  // Complementary pins only drive in combined modes
  assign rt.timer_oe = {timer_oe_i[5:4] & {2{combined}}, timer_oe_i[3:0]};
  assign pin_o = rt.pin_o;
  assign pin_oe_n_o = rt.pin_oe_n;

  pin_route u_route (
    .rt(rt.route)
  );

  reset_value_a: assert property (@(posedge clk_i) rst_i |=> comb_rd == 8'hc0 && en_rd == 8'hff)
    else $error("reset values wrong");
  reserved_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comb_rd[7:6] == 2'b11 && en_rd[7:6] == 2'b11) else $error("reserved bits not one");
  standby_init_a: assert property (@(posedge clk_i) disable iff (rst_i)
    standby_i |=> st.comb == 6'h00 && st.enable == 6'h3f) else $error("standby init");
  pwm_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comb_mode_o[1] |-> !ch3_pwm_eff_o && !ch4_pwm_eff_o) else $error("pwm not ignored");
  sync_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ch3_sync_eff_o == ch3_sync_select_i) else $error("sync lost");
  trig_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ch1_capture_a_i && !st.trig_disable && combined && !standby_i |=> st.enable == 6'h00)
    else $error("trigger did not clear");
  trig_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !combined && !wr && !standby_i |=> st.enable == $past(st.enable))
    else $error("enable changed in normal");
  pin_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.enable[3] |-> pin_oe_n_o[3]) else $error("disabled pin driven");
  buf_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == addr_comb_ctrl && !standby_i |=> buffer_select_o == $past(dat_i[3:0]))
    else $error("buffer select not written");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held");
endmodule : pwm_comb_ctrl

/* pkg/pwm_comb_pkg.sv */
package pwm_comb_pkg;
  localparam logic [3:0] addr_comb_ctrl = 4'h0;
  localparam logic [3:0] addr_out_enable = 4'h4;
  localparam logic [3:0] addr_trig_ctrl = 4'h8;
  localparam logic [7:0] comb_ctrl_reset = 8'hc0;
  localparam logic [7:0] out_enable_reset = 8'hff;
  localparam logic [7:0] reserved_mask = 8'hc0;
  localparam logic [7:0] trig_ctrl_reset = 8'h01;
  localparam int mode_lsb = 4;
  localparam int trig_disable_bit = 0;
  typedef enum logic [1:0] {
    mode_normal0 = 2'b00,
    mode_normal1 = 2'b01,
    mode_complementary = 2'b10,
    mode_reset_sync = 2'b11
  } comb_mode_e;
endpackage : pwm_comb_pkg

/* pkg/pwm_route_if.sv */
`timescale 1ns/1ps
interface pwm_route_if;
  logic combined;
  logic [5:0] enable;
  logic [5:0] timer_out;
  logic [5:0] timer_oe;
  logic [5:0] pin_o;
  logic [5:0] pin_oe_n;
  modport ctrl (output combined, output enable, output timer_out, output timer_oe,
                input pin_o, input pin_oe_n);
  modport route (input combined, input enable, input timer_out, input timer_oe,
                 output pin_o, output pin_oe_n);
endinterface : pwm_route_if

/* sim/combined_pwm_mode_output_enable_test.sv */
`timescale 1ns/1ps
module combined_pwm_mode_output_enable_test;
  import pwm_comb_pkg::*;
  logic clk_i = 0, rst_i = 1, standby_i = 0, cyc_i = 0, stb_i = 0, we_i = 0, cap_i = 0;
  logic ack_o, p3, p4, s3, s4;
  logic [3:0] adr_i = 0, sel_i = 4'h1, psel = 0, bsel;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic [5:0] to_i = 0, oe_i = 0, pin_o, pin_oe_n_o;
  logic [1:0] mode_o;
  logic [7:0] comb = 8'hc0, oen = 8'hff, d;
  integer seed = 78, num_errors = 0, comparisons = 0, i;

  pwm_comb_ctrl pwm_comb_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ch1_capture_a_i(cap_i), .ch3_pwm_select_i(psel[3]),
    .ch4_pwm_select_i(psel[2]), .ch3_sync_select_i(psel[1]), .ch4_sync_select_i(psel[0]),
    .timer_out_i(to_i), .timer_oe_i(oe_i), .comb_mode_o(mode_o), .ch3_pwm_eff_o(p3),
    .ch4_pwm_eff_o(p4), .ch3_sync_eff_o(s3), .ch4_sync_eff_o(s4), .buffer_select_o(bsel),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));

  initial forever #25 clk_i = ~clk_i;

  task give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; waits for ack under a bounded count
  task wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    integer n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask : wb

  task rdchk(input logic [3:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdchk

  task pins;
    logic [3:0] ps;
    ps = $random(seed);
    // Complementary mode never gets both sync selects set
    if (comb[5:4] == 2'b10) ps[0] = 1'b0;
    @(posedge clk_i);
    to_i <= $random(seed);
    oe_i <= $random(seed);
    psel <= ps;
    #1;
    chk(pin_o, oen[5:0] & to_i);
    chk(pin_oe_n_o, 6'(~(oen[5:0] & oe_i & {{2{comb[5]}}, 4'hf})));
    chk({mode_o, bsel}, comb[5:0]);
    chk({p3, p4, s3, s4}, {psel[3:2] & {2{~comb[5]}}, psel[1:0]});
  endtask : pins

  task pulse;
    @(posedge clk_i) cap_i <= 1;
    @(posedge clk_i) cap_i <= 0;
  endtask : pulse

  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rdchk(addr_comb_ctrl, 8'hc0);
    rdchk(addr_out_enable, 8'hff);
    rdchk(4'hc, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      d[5:4] = i[1:0];
      comb = {2'b11, d[5:0]};
      wb(1, addr_comb_ctrl, d); // no counters run in this bench
      rdchk(addr_comb_ctrl, comb);
      d = $random(seed);
      oen = d | 8'hc0;
      wb(1, addr_out_enable, d);
      rdchk(addr_out_enable, oen);
      pins;
    end
    oen = 8'hff;
    wb(1, addr_out_enable, oen);
    wb(1, addr_comb_ctrl, 8'h20);
    pulse;
    rdchk(addr_out_enable, 8'hff);
    wb(1, addr_trig_ctrl, 8'h00);
    wb(1, addr_comb_ctrl, 8'h10);
    pulse;
    rdchk(addr_out_enable, 8'hff);
    wb(1, addr_comb_ctrl, 8'h30);
    comb = 8'hf0;
    pulse;
    oen = 8'hc0;
    rdchk(addr_out_enable, oen);
    pins;
    @(posedge clk_i) standby_i <= 1;
    @(posedge clk_i) standby_i <= 0;
    rdchk(addr_comb_ctrl, 8'hc0);
    rdchk(addr_out_enable, 8'hff);
    rdchk(addr_trig_ctrl, trig_ctrl_reset);
    give_verdict;
  end
endmodule : combined_pwm_mode_output_enable_test
